// *** hw/rmmc_top.sv ***
// Byte buffer and operating-mode controller of the radio module.

// ************************************************************
// Byte FIFO with valid and ready on both sides.
// ************************************************************
module rmmc_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             in_valid,
   output      logic             in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output      logic             out_valid,
   input  wire logic             out_ready,
   output      logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];   // Storage words.
   logic [AW:0]      wr_ptr_q;        // Write pointer with wrap bit.
   logic [AW:0]      rd_ptr_q;        // Read pointer with wrap bit.
   wire              empty;           // Nothing stored.
   wire              full;            // No free word.
   wire              push;            // Word accepted this cycle.
   wire              pop;             // Word leaves this cycle.

   // Full when the pointers differ only in the wrap bit.
   assign empty     = (wr_ptr_q == rd_ptr_q);
   assign full      = (wr_ptr_q[AW] != rd_ptr_q[AW]) && (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]);
   assign in_ready  = !full;
   assign out_valid = !empty;
   assign push      = in_valid && !full;
   assign pop       = out_ready && !empty;
   assign out_data  = mem_q[rd_ptr_q[AW-1:0]];

   // Pointers advance on each accepted push and pop.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
      end else begin
         if (push) wr_ptr_q <= wr_ptr_q + 1'b1;
         if (pop)  rd_ptr_q <= rd_ptr_q + 1'b1;
      end
   end

   // Storage is written without reset; empty words are never read out.
   always_ff @(posedge clk) begin
      if (push) mem_q[wr_ptr_q[AW-1:0]] <= in_data;
   end
endmodule

// ************************************************************
// Mode controller top level.
// ************************************************************
module rmmc_top
   import rmmc_pkg::*;
#(
   parameter int unsigned SETTLE_LEN = SETTLE_CYCLES,
   parameter int unsigned RSSI_LEN   = RSSI_CYCLES
) (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        mode_select_0,
   input  wire logic        mode_select_1,
   input  wire logic        mode_select_2,
   input  wire logic        setup_done,
   input  wire logic        host_valid,
   output      logic        host_ready,
   input  wire logic [7:0]  host_data,
   output      logic        air_tx_valid,
   input  wire logic        air_tx_ready,
   output      logic [7:0]  air_tx_data,
   input  wire logic        air_tx_busy,
   input  wire logic        uart_out_busy,
   input  wire logic [7:0]  rssi_level,
   output      logic        rssi_send,
   output      logic [7:0]  rssi_byte,
   input  wire logic [2:0]  baud_sel,
   input  wire logic [2:0]  rate_setting_field,
   input  wire logic [2:0]  wor_grade,
   output      logic [2:0]  uart_baud,
   output      logic [2:0]  air_rate,
   output      logic [2:0]  wor_interval,
   input  wire logic [15:0] own_addr,
   input  wire logic [15:0] rx_dest_addr,
   output      logic        tx_broadcast,
   output      logic        rx_accept,
   output      rmmc_ctrl_s  mode_ctrl,
   output      logic [2:0]  active_mode,
   output      logic        reconf_req,
   output      logic        wake_pulse,
   output      logic        status_ready
);

   // ************************************************************
   // Pin synchronisers and edge detection.
   // ************************************************************
   logic [2:0] pin_meta_q;   // First stage, read only by the second stage.
   logic [2:0] pin_sync_q;   // Synchronised pin levels.
   logic [2:0] pin_prev_q;   // Previous synchronised levels.
   wire  [2:0] pin_fall;     // Falling edge on each pin.

   // Two stages, then a history stage for edges.
   // Pins synchronised first.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_meta_q <= 3'h7;
         pin_sync_q <= 3'h7;
         pin_prev_q <= 3'h7;
      end else begin
         pin_meta_q <= {mode_select_2, mode_select_1, mode_select_0};
         pin_sync_q <= pin_meta_q;
         pin_prev_q <= pin_sync_q;
      end
   end

   // Pin 2 is the top bit.
   wire [2:0] pin_mode = pin_sync_q;
   assign pin_fall = pin_prev_q & ~pin_sync_q;

   // ************************************************************
   // Host data buffer toward the radio.
   // ************************************************************
   rmmc_ctrl_s ctrl_q;        // Enables of the mode in force.
   wire        fifo_in_rdy;   // Buffer has room.
   wire        fifo_out_vld;  // Buffer holds a byte.
   wire        fifo_out_rdy;  // Byte taken or dropped.
   wire        busy;          // Work still pending in the current mode.

   // Bytes enter only while the UART is open.
   assign host_ready   = fifo_in_rdy && ctrl_q.uart_en;
   // Without transmission the bytes are drained and dropped.
   assign fifo_out_rdy = air_tx_ready || !ctrl_q.tx_en;
   assign air_tx_valid = fifo_out_vld && ctrl_q.tx_en;

   rmmc_fifo #(
      .WIDTH (FIFO_WIDTH),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk       (clk),
      .rst_n     (rst_n),
      .in_valid  (host_valid && ctrl_q.uart_en),
      .in_ready  (fifo_in_rdy),
      .in_data   (host_data),
      .out_valid (fifo_out_vld),
      .out_ready (fifo_out_rdy),
      .out_data  (air_tx_data)
   );

   // Unsent bytes and airing count as busy.
   // UART output of received data counts as busy.
   // Queued host bytes hold the switch.
   assign busy = fifo_out_vld || air_tx_busy || uart_out_busy;

   // ************************************************************
   // Mode switching state machine.
   // ************************************************************
   rmmc_state_e             state_q;    // Controller state.
   rmmc_state_e             state_d;    // Next controller state.
   logic [2:0]              mode_q;     // Mode in force.
   logic [2:0]              target_q;   // Mode waiting to be applied.
   logic [SETTLE_CNT_W-1:0] settle_q;   // Cycles spent settling.
   wire                     settle_end; // Settle period has run out.
   wire                     apply;      // New mode takes effect.
   wire                     leave_cfg;  // Applying leaves configuration.
   rmmc_ctrl_s              target_ctrl; // Enables of the waiting mode.

   assign settle_end = (settle_q == SETTLE_CNT_W'(SETTLE_LEN - 1));
   assign apply      = (state_q == ST_SETTLE) && !busy && (pin_mode == target_q) && settle_end;
   assign target_ctrl = rmmc_decode(target_q);
   assign leave_cfg  = ctrl_q.cfg_en && !target_ctrl.cfg_en;

   // Next state selection.
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         // Initialisation holds until setup is done.
         ST_INIT:    if (setup_done) state_d = ST_RUN;
         // A pin change starts the settle period or waits for idle.
         ST_RUN:     if (pin_mode != mode_q) state_d = busy ? ST_PENDING : ST_SETTLE;
         ST_PENDING: if (!busy) state_d = ST_SETTLE;
         ST_SETTLE: begin
            if (busy) state_d = ST_PENDING;
            else if (pin_mode == mode_q) state_d = ST_RUN;
            else if (apply) state_d = leave_cfg ? ST_RECONF : ST_RUN;
         end
         ST_RECONF:  if (setup_done) state_d = ST_RUN;
      endcase
   end

   // State, target and settle counter.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q  <= ST_INIT;
         target_q <= MODE_RESET;
         settle_q <= '0;
      end else begin
         state_q  <= state_d;
         target_q <= pin_mode;
         // Restart the count when busy or the pins move.
         if (state_q != ST_SETTLE || busy || pin_mode != target_q) settle_q <= '0;
         else if (!settle_end) settle_q <= settle_q + 1'b1;
      end
   end

   // Mode in force: caught at initialisation end, replaced on apply.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_q <= MODE_RESET;
         ctrl_q <= CTRL_RESET;
      end else if ((state_q == ST_INIT && setup_done) || apply) begin
         mode_q <= pin_mode;
         ctrl_q <= rmmc_decode(pin_mode);
      end
   end

   assign active_mode  = mode_q;
   assign mode_ctrl    = ctrl_q;
   assign reconf_req   = (state_q == ST_RECONF);
   // Status high only when idle and initialised.
   assign status_ready = (state_q != ST_INIT) && (state_q != ST_RECONF) && !busy;

   // ************************************************************
   // Signal-strength reporting, rates and wake events.
   // ************************************************************
   logic [RSSI_CNT_W-1:0] rssi_cnt_q;  // Cycles since last report.
   wire                   rssi_due;    // Report period has run out.
   wire                   in_rssi;     // Strength mode in force.
   logic                  rssi_send_q; // One-cycle report strobe.
   logic [7:0]            rssi_byte_q; // Reported strength byte.
   logic [2:0]            baud_q;      // UART rate code.
   logic [2:0]            air_q;       // Air rate code.
   logic [2:0]            wor_q;       // Wake interval grade.
   logic                  wake_q;      // Wake event strobe.

   assign in_rssi  = (mode_q == MODE_RSSI) && (state_q != ST_INIT);
   assign rssi_due = (rssi_cnt_q == RSSI_CNT_W'(RSSI_LEN - 1));

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rssi_cnt_q  <= '0;
         rssi_send_q <= 1'b0;
         rssi_byte_q <= 8'h00;
      end else begin
         rssi_cnt_q  <= (!in_rssi || rssi_due) ? '0 : rssi_cnt_q + 1'b1;
         rssi_send_q <= in_rssi && rssi_due;
         if (in_rssi && rssi_due) rssi_byte_q <= rssi_level;
      end
   end

   // Rate and wake outputs follow the mode in force.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         baud_q <= RATE_RESET;
         air_q  <= RATE_RESET;
         wor_q  <= RATE_RESET;
         wake_q <= 1'b0;
      end else begin
         // Configuration codes fix the UART rate.
         baud_q <= ctrl_q.cfg_en ? BAUD_9600 : baud_sel;
         air_q  <= ctrl_q.auto_rate ? baud_sel : rate_setting_field;
         // Interval grade only in power saving receive.
         wor_q  <= ctrl_q.wor_rx ? wor_grade : RATE_RESET;
         // Any falling pin edge wakes from sleep.
         wake_q <= ctrl_q.sleep_en && (|pin_fall);
      end
   end

   assign rssi_send    = rssi_send_q;
   assign rssi_byte    = rssi_byte_q;
   assign uart_baud    = baud_q;
   assign air_rate     = air_q;
   assign wor_interval = wor_q;
   assign wake_pulse   = wake_q;

   // Broadcast addresses reach and hear everyone.
   wire own_bcast = (own_addr == ADDR_BCAST_LO) || (own_addr == ADDR_BCAST_HI);
   assign tx_broadcast = own_bcast;
   assign rx_accept    = own_bcast || (rx_dest_addr == own_addr);

   // ************************************************************
   // Assertions.
   // ************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_init_status_low: assert property (state_q == ST_INIT |-> !status_ready)
      else $error("Status high during initialisation.");
   a_reconf_status_low: assert property ($rose(reconf_req) |-> !status_ready [*2])
      else $error("Status high during reconfiguration.");
   a_busy_status_low: assert property (busy |-> !status_ready)
      else $error("Status high while work is pending.");
   a_mode_only_settled: assert property ($changed(mode_q) && !$past(state_q == ST_INIT)
      |-> $past(settle_end) && $past(state_q == ST_SETTLE))
      else $error("Mode changed without a full settle period.");
   a_busy_holds_mode: assert property (busy |=> $stable(mode_q))
      else $error("Mode changed while busy.");
   a_mode_matches_pins: assert property ($changed(mode_q) |-> mode_q == $past(pin_mode))
      else $error("Applied mode differs from the pins.");
   a_rssi_in_mode0: assert property (rssi_send |-> $past(mode_q) == MODE_RSSI)
      else $error("Strength byte outside mode 0.");
   a_cfg_fixed_baud: assert property (ctrl_q.cfg_en && $past(ctrl_q.cfg_en)
      |-> uart_baud == BAUD_9600 && !ctrl_q.tx_en)
      else $error("Configuration mode without fixed baud.");
   a_auto_air_rate: assert property (mode_q == MODE_CONT && $stable(mode_q)
      |=> air_rate == $past(baud_sel))
      else $error("Continuous mode air rate not derived from baud.");
   a_wake_preamble: assert property (mode_q == MODE_WAKE |-> ctrl_q.wake_pre && !ctrl_q.rx_en)
      else $error("Wake mode enables wrong.");
   a_sleep_wake: assert property (ctrl_q.sleep_en && (|pin_fall) |=> wake_pulse)
      else $error("Falling pin edge missed in sleep.");
   a_bcast_accept: assert property (own_addr == ADDR_BCAST_HI |-> rx_accept && tx_broadcast)
      else $error("Broadcast address not honoured.");
endmodule

// *** hw/rmmc_pkg.sv ***
// Shared constants, types and mode decoding for the radio mode controller.
package rmmc_pkg;

   // ************************************************************
   // Clock and timing constants.
   // ************************************************************
   localparam int CLK_FREQ_KHZ   = 40000;                              // Core clock, 40 MHz.
   localparam int SETTLE_TIME_US = 1000;                               // Delay before a new mode.
   localparam int SETTLE_CYCLES  = SETTLE_TIME_US * CLK_FREQ_KHZ / 1000; // Settle in cycles.
   localparam int RSSI_PERIOD_MS = 100;                                // Strength report period.
   localparam int RSSI_CYCLES    = RSSI_PERIOD_MS * CLK_FREQ_KHZ;      // Report period in cycles.
   localparam int SETTLE_CNT_W   = 16;                                 // Settle counter width.
   localparam int RSSI_CNT_W     = 22;                                 // Report counter width.

   // ************************************************************
   // Buffer shape.
   // ************************************************************
   localparam int FIFO_WIDTH = 8;                                      // One UART byte.
   localparam int FIFO_DEPTH = 16;                                     // Words in the buffer.

   // ************************************************************
   // Mode codes, as read from the three select pins.
   // ************************************************************
   localparam logic [2:0] MODE_RSSI  = 3'h0;                           // Strength reporting.
   localparam logic [2:0] MODE_CONT  = 3'h1;                           // Continuous transfer.
   localparam logic [2:0] MODE_SUB   = 3'h2;                           // Sub-packet transfer.
   localparam logic [2:0] MODE_CFG   = 3'h3;                           // Configuration.
   localparam logic [2:0] MODE_WAKE  = 3'h4;                           // Wake transmitter.
   localparam logic [2:0] MODE_CFG2  = 3'h5;                           // Second configuration code.
   localparam logic [2:0] MODE_SAVE  = 3'h6;                           // Power saving receive.
   localparam logic [2:0] MODE_SLEEP = 3'h7;                           // Sleep.
   localparam logic [2:0] MODE_RESET = 3'h0;                           // Mode held during reset.

   // ************************************************************
   // Rate codes, addresses and reset values.
   // ************************************************************
   localparam logic [2:0]  BAUD_9600     = 3'h3;                       // Fixed 9600 8N1 code.
   localparam logic [2:0]  RATE_RESET    = 3'h0;                       // Rate outputs at reset.
   localparam logic [15:0] ADDR_BCAST_LO = 16'h0000;                   // Broadcast address.
   localparam logic [15:0] ADDR_BCAST_HI = 16'hFFFF;                   // Broadcast address.

   // Per-mode enables driven to the UART and radio.
   typedef struct packed {
      logic uart_en;    // UART open.
      logic rx_en;      // Radio reception allowed.
      logic tx_en;      // Radio transmission allowed.
      logic cfg_en;     // Parameter configuration accepted.
      logic wake_pre;   // Wake preamble ahead of each transmission.
      logic wor_rx;     // Periodic wake-on-radio reception.
      logic sleep_en;   // Sleep.
      logic auto_rate;  // Air rate derived from the baud rate.
   } rmmc_ctrl_s;

   localparam rmmc_ctrl_s CTRL_RESET = '0;                             // All off during reset.

   // Controller states.
   typedef enum logic [2:0] {ST_INIT, ST_RUN, ST_PENDING, ST_SETTLE, ST_RECONF} rmmc_state_e;

   // Maps a mode code onto its enables.
   function automatic rmmc_ctrl_s rmmc_decode(input logic [2:0] m);
      rmmc_ctrl_s c;
      c = '0;
      unique case (m)
         MODE_RSSI:  c.uart_en = 1'b1;
         MODE_CONT:  c = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
         MODE_SUB:   c = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
         MODE_CFG:   c = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
         // Wake mode: no reception, preamble on transmit.
         MODE_WAKE:  c = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
         // Second code decodes exactly as configuration.
         MODE_CFG2:  c = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
         MODE_SAVE:  c.wor_rx = 1'b1;
         MODE_SLEEP: c.sleep_en = 1'b1;
      endcase
      return c;
   endfunction

endpackage

// *** dv/rmmc_host_model.sv ***
// Host microcontroller model that drives the mode pins and the UART byte stream.
module rmmc_host_model #(
   parameter int unsigned SETTLE = 20
) (
   input  wire logic       clk,
   input  wire logic       host_ready,
   input  wire logic       status_ready,
   output      logic       mode_select_0,
   output      logic       mode_select_1,
   output      logic       mode_select_2,
   output      logic       host_valid,
   output      logic [7:0] host_data
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [2:0] pins_q = 3'h2; // Pin levels; the start value selects sub-packet mode.
   assign {mode_select_2, mode_select_1, mode_select_0} = pins_q;
   initial begin
      host_valid = 1'b0;
      host_data  = 8'h00;
   end
   // Moves the pins; a polite host first waits for idle plus the margin.
   task automatic set_mode(input logic [2:0] m, input bit polite);
      int n;
      n = 0;
      if (polite) begin
         while (status_ready !== 1'b1 && n < 4000) begin
            @(posedge clk);
            n++;
         end
         repeat (2 * SETTLE) @(posedge clk);
         #2;
      end
      pins_q = m;
   endtask
   // Offers one byte and holds it until an edge that sees ready high, or gives up.
   task automatic push(input logic [7:0] b, output bit ok);
      int n;
      ok = 1'b0;
      host_valid = 1'b1;
      host_data = b;
      for (n = 0; n < 4 && !ok; n++) begin
         ok = (host_ready === 1'b1);
         @(posedge clk);
         #2;
      end
   endtask
   // Releases the line; the data shows the inverse of the last byte, not a stale copy.
   task automatic idle();
      host_valid = 1'b0;
      host_data = ~host_data;
   endtask
endmodule

// *** dv/radio_module_mode_control_tb.sv ***
// Self-checking bench for the radio mode controller with random and corner stimulus.
module radio_module_mode_control_tb
   import rmmc_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int SL = 20; // Shortened settle count.
   localparam int RL = 50; // Shortened report period.
   logic clk = 1'b0, rst_n = 1'b0, setup_done = 1'b0, air_tx_ready = 1'b1;
   logic air_tx_busy = 1'b0, uart_out_busy = 1'b0;
   logic m0, m1, m2, host_valid, host_ready, air_tx_valid, rssi_send, tx_broadcast;
   logic rx_accept, reconf_req, wake_pulse, status_ready;
   logic [7:0] host_data, air_tx_data, rssi_byte, rssi_level = 8'h00;
   logic [2:0] baud_sel = 3'h0, rate_setting_field = 3'h0, wor_grade = 3'h0;
   logic [2:0] uart_baud, air_rate, wor_interval, active_mode;
   logic [15:0] own_addr = 16'h1234, rx_dest_addr = 16'h0000;
   rmmc_ctrl_s mode_ctrl;
   int n_fail = 0, n_checks = 0;
   always #12.5 clk = ~clk;
   rmmc_top #(.SETTLE_LEN(SL), .RSSI_LEN(RL)) u_dut (.clk(clk), .rst_n(rst_n),
      .mode_select_0(m0), .mode_select_1(m1), .mode_select_2(m2), .setup_done(setup_done),
      .host_valid(host_valid), .host_ready(host_ready), .host_data(host_data),
      .air_tx_valid(air_tx_valid), .air_tx_ready(air_tx_ready), .air_tx_data(air_tx_data),
      .air_tx_busy(air_tx_busy), .uart_out_busy(uart_out_busy), .rssi_level(rssi_level),
      .rssi_send(rssi_send), .rssi_byte(rssi_byte), .baud_sel(baud_sel),
      .rate_setting_field(rate_setting_field), .wor_grade(wor_grade), .uart_baud(uart_baud),
      .air_rate(air_rate), .wor_interval(wor_interval), .own_addr(own_addr),
      .rx_dest_addr(rx_dest_addr), .tx_broadcast(tx_broadcast), .rx_accept(rx_accept),
      .mode_ctrl(mode_ctrl), .active_mode(active_mode), .reconf_req(reconf_req),
      .wake_pulse(wake_pulse), .status_ready(status_ready));
   rmmc_host_model #(.SETTLE(SL)) u_host (.clk(clk), .host_ready(host_ready),
      .status_ready(status_ready), .mode_select_0(m0), .mode_select_1(m1),
      .mode_select_2(m2), .host_valid(host_valid), .host_data(host_data));
   // Expected enables per mode, most significant bit the UART enable.
   function automatic logic [7:0] exp_ctrl(input logic [2:0] m);
      logic [7:0] t [8];
      t = '{8'h80, 8'hE1, 8'hE0, 8'h90, 8'hA8, 8'h90, 8'h04, 8'h02};
      return t[m];
   endfunction
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wait_mode(input logic [2:0] m, input int lim);
      for (int n = 0; n < lim && active_mode !== m; n++) step(1);
   endtask
   // Polite switch with timing, reconfiguration and per-mode output checks.
   task automatic go(input logic [2:0] m);
      logic [2:0] was;
      was = active_mode;
      // Random baud, air rate and wake grade for this switch.
      {baud_sel, rate_setting_field, wor_grade} = 9'($urandom);
      u_host.set_mode(m, 1'b1);
      step(SL);
      chk("mode held", 16'(was), 16'(active_mode));
      wait_mode(m, 8);
      chk("mode", 16'(m), 16'(active_mode));
      if (was == MODE_CFG || was == MODE_CFG2) begin
         chk("reconf", 16'h0002, {14'h0, reconf_req, status_ready});
         step(1);
         chk("reconf held", 16'h0002, {14'h0, reconf_req, status_ready});
         setup_done = 1'b1;
         step(1);
         setup_done = 1'b0;
      end
      step(3);
      chk("ctrl", 16'(exp_ctrl(m)), 16'(mode_ctrl));
      chk("baud", 16'((m == 3 || m == 5) ? 3'h3 : baud_sel), 16'(uart_baud));
      chk("air", 16'((m == 1) ? baud_sel : rate_setting_field), 16'(air_rate));
      chk("wor", 16'((m == 6) ? wor_grade : 3'h0), 16'(wor_interval));
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   initial begin
      #400000;
      n_fail++;
      final_report();
   end
   initial begin
      bit ok;
      int n;
      logic [7:0] q [$];
      void'($urandom(32'hb635_60be));
      step(5);
      chk("status in reset", 16'h0, 16'(status_ready));
      rst_n = 1'b1;
      step(4);
      chk("status init", 16'h0, 16'(status_ready));
      setup_done = 1'b1;
      step(1);
      setup_done = 1'b0;
      step(1);
      chk("status up", 16'h1, 16'(status_ready));
      $display("test reset done");
      // Fill the buffer with the radio stalled, switch mid-stream, then drain.
      air_tx_ready = 1'b0;
      n = 0;
      for (int i = 0; i < 17; i++) begin
         u_host.push(8'($urandom), ok);
         if (ok) q.push_back(host_data);
         n += ok;
      end
      u_host.idle();
      chk("fifo fill", 16'd16, 16'(n));
      u_host.set_mode(MODE_WAKE, 1'b0);
      step(2 * SL);
      chk("deferred", 16'(MODE_SUB), 16'(active_mode));
      for (n = 0; n < 400 && q.size() > 0; n++) begin
         air_tx_ready = 1'($urandom);
         if (air_tx_valid === 1'b1 && air_tx_ready) chk("tx data", 16'(q.pop_front()), 16'(air_tx_data));
         step(1);
      end
      air_tx_ready = 1'b1;
      chk("drained", 16'h0, 16'(q.size()));
      wait_mode(MODE_WAKE, SL + 8);
      chk("after drain", 16'(MODE_WAKE), 16'(active_mode));
      $display("test fifo done");
      // Either busy source holds a change back, and release lets it through.
      for (int i = 0; i < 2; i++) begin
         {uart_out_busy, air_tx_busy} = 2'(i + 1);
         u_host.set_mode(i ? MODE_SUB : MODE_RSSI, 1'b0);
         step(3 * SL);
         chk("busy hold", {12'h0, i ? MODE_RSSI : MODE_WAKE, 1'b0}, {12'h0, active_mode, status_ready});
         {uart_out_busy, air_tx_busy} = 2'b00;
         wait_mode(i ? MODE_SUB : MODE_RSSI, SL + 8);
         chk("busy release", 16'(i ? MODE_SUB : MODE_RSSI), 16'(active_mode));
      end
      $display("test busy done");
      for (int m = 0; m < 8; m++) go(3'(m));
      $display("test modes done");
      u_host.set_mode(MODE_RSSI, 1'b0);
      n = 0;
      for (int i = 0; i < 8; i++) begin
         n += (wake_pulse === 1'b1);
         step(1);
      end
      chk("wake pulses", 16'h1, 16'(n));
      wait_mode(MODE_RSSI, SL + 8);
      rssi_level = 8'($urandom);
      for (n = 0; n < RL + 5 && rssi_send !== 1'b1; n++) step(1);
      step(1);
      for (n = 1; n < RL + 5 && rssi_send !== 1'b1; n++) step(1);
      chk("rssi period", 16'(RL), 16'(n));
      chk("rssi byte", 16'(rssi_level), 16'(rssi_byte));
      $display("test wake and rssi done");
      for (int k = 0; k < 4; k++) begin
         own_addr = (k == 0) ? 16'h0000 : (k == 1) ? 16'hFFFF : 16'h0100 | 16'($urandom % 255);
         rx_dest_addr = (k == 3) ? own_addr : 16'h0200;
         step(1);
         chk("bcast", 16'(k < 2), 16'(tx_broadcast));
         chk("accept", 16'(k != 2), 16'(rx_accept));
      end
      $display("test address done");
      final_report();
   end
endmodule
